// ### design/hpfa_regs.svh
// constants of the port-to-fifo arbiter
`ifndef HPFA_REGS_SVH
`define HPFA_REGS_SVH

// ----------------------------------------------------------------
// structure sizes
// ----------------------------------------------------------------
`define HPFA_NPORTS   16
`define HPFA_NFAST    2
`define HPFA_WORD_W   32
`define HPFA_PORT_W   4
`define HPFA_CHAN_W   8
`define HPFA_CNT_W    5
`define HPFA_LAST_BIT 5'h1F

`endif

// ### design/hpfa_pkg.sv
// types and helpers shared by the port-to-fifo arbiter
package hpfa_pkg;
`include "hpfa_regs.svh"

    typedef logic [`HPFA_WORD_W-1:0]  hpfa_word_type;
    typedef logic [`HPFA_PORT_W-1:0]  hpfa_port_type;
    typedef logic [`HPFA_CHAN_W-1:0]  hpfa_chan_type;
    typedef logic [`HPFA_NPORTS-1:0]  hpfa_vec_type;
    typedef logic [`HPFA_NFAST-1:0]   hpfa_fvec_type;

    typedef enum logic [1:0] {TX_IDLE, TX_FETCH, TX_DONE} hpfa_tx_type;

    typedef struct packed {
        hpfa_word_type           shift;
        logic [`HPFA_CNT_W-1:0]  cnt;
        hpfa_word_type           hold;
        logic                    full;
        logic                    ovr;
    } hpfa_pack_type;

    typedef struct packed {
        logic          wr_valid;
        hpfa_word_type wr_data;
        hpfa_port_type wr_port;
        hpfa_chan_type wr_chan;
        hpfa_tx_type   tx_st;
        hpfa_port_type rd_port;
        hpfa_word_type tx_word;
        hpfa_vec_type  tx_valid;
        hpfa_fvec_type tx_fast_valid;
    } hpfa_top_type;

    // lowest set bit wins: {found, index}
    function automatic logic [`HPFA_PORT_W:0] hpfa_lowest(
        input hpfa_vec_type v);
        logic [`HPFA_PORT_W:0] r;
        r = '0;
        for (int i = `HPFA_NPORTS - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = {1'b1, hpfa_port_type'(i)};
            end
        end
        return r;
    endfunction
endpackage

// ### design/hpfa_packer.sv
// serial-to-dword packer of one receive protocol engine
`timescale 1ns/1ps
`default_nettype none
module hpfa_packer (
    // clock and reset
    input  wire logic                   clock,
    input  wire logic                   nrst,
    // serial bits from the engine
    input  wire logic                   bit_in,
    input  wire logic                   bit_en,
    input  wire logic                   chan_en,
    // transfer handshake
    input  wire logic                   grant,
    output logic                        req,
    output hpfa_pkg::hpfa_word_type     dword,
    output logic                        overrun
);
    import hpfa_pkg::*;

    hpfa_pack_type s_r;
    hpfa_pack_type s_nxt;
    logic          take;

    assign take = bit_en && chan_en;

    // ----------------------------------------------------------------
    // packing
    // ----------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        if (grant) begin
            s_nxt.full = 1'b0;
        end
        if (take) begin
            s_nxt.shift = {s_r.shift[`HPFA_WORD_W-2:0], bit_in};
            s_nxt.cnt   = s_r.cnt + 1'b1;
            if (s_r.cnt == `HPFA_LAST_BIT) begin
                // a second word landing on an unserved one is lost
                if (!s_r.full || grant) begin
                    s_nxt.hold = {s_r.shift[`HPFA_WORD_W-2:0], bit_in};
                    s_nxt.full = 1'b1;
                end else begin
                    s_nxt.ovr = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign req     = s_r.full;
    assign dword   = s_r.hold;
    assign overrun = s_r.ovr;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    property p_word_done;
        take && s_r.cnt == `HPFA_LAST_BIT && !s_r.full |=>
            req && dword == $past({s_r.shift[`HPFA_WORD_W-2:0], bit_in});
    endproperty
    a_word_done: assert property (p_word_done)
        else $error("packer did not present a full dword");

    property p_drop_after_grant;
        grant && !(take && s_r.cnt == `HPFA_LAST_BIT) |=> !req;
    endproperty
    a_drop_after_grant: assert property (p_drop_after_grant)
        else $error("request still high after grant");

    property p_hold_stable;
        req && !grant |=> req && $stable(dword);
    endproperty
    a_hold_stable: assert property (p_hold_stable)
        else $error("dword changed while waiting for grant");

    property p_chan_off;
        !chan_en |=> $stable(s_r.cnt);
    endproperty
    a_chan_off: assert property (p_chan_off)
        else $error("bits packed on a disabled channel");
endmodule
`default_nettype wire

// ### design/hpfa_arbiter.sv
// fixed-priority transfer arbiter between port engines and the fifo
//
// How it works
// - engines pack bits into dwords, then request
// - lowest-numbered requesting port always wins
// - priority uses physical port, never channel
// - sixteen slow engines, one per port
// - fast engines exist on ports zero, one
// - port control selects slow or fast engine
// - path sustains full rate without loss while the fifo accepts writes
// - only enabled bound channels feed engines
// - transmit requests use same fixed priority
// - fifo delivers transmit data one word each
`timescale 1ns/1ps
`default_nettype none
`include "hpfa_regs.svh"
module hpfa_arbiter (
    // clock and reset
    input  wire logic                   clock,
    input  wire logic                   nrst,
    // engine selection, high picks the fast engine
    input  wire logic [1:0]             rx_port_control,
    input  wire logic [1:0]             tx_port_control,
    // receive bits from slow engines
    input  wire hpfa_pkg::hpfa_vec_type rx_bit,
    input  wire hpfa_pkg::hpfa_vec_type rx_bit_en,
    // receive bits from fast engines
    input  wire hpfa_pkg::hpfa_fvec_type fast_rx_bit,
    input  wire hpfa_pkg::hpfa_fvec_type fast_rx_bit_en,
    // channel binding per port
    input  wire hpfa_pkg::hpfa_vec_type rx_chan_en,
    input  wire hpfa_pkg::hpfa_chan_type rx_chan [`HPFA_NPORTS],
    // overrun flags
    output hpfa_pkg::hpfa_vec_type      rx_overrun,
    output hpfa_pkg::hpfa_fvec_type     fast_rx_overrun,
    // fifo write side
    output logic                        fifo_wr_valid,
    input  wire logic                   fifo_wr_ready,
    output hpfa_pkg::hpfa_word_type     fifo_wr_data,
    output hpfa_pkg::hpfa_port_type     fifo_wr_port,
    output hpfa_pkg::hpfa_chan_type     fifo_wr_chan,
    // transmit word requests from engines
    input  wire hpfa_pkg::hpfa_vec_type tx_req,
    input  wire hpfa_pkg::hpfa_fvec_type tx_fast_req,
    // fifo read side
    output logic                        fifo_rd_req,
    output hpfa_pkg::hpfa_port_type     fifo_rd_port,
    input  wire logic                   fifo_rd_valid,
    input  wire hpfa_pkg::hpfa_word_type fifo_rd_data,
    // transmit words to engines
    output hpfa_pkg::hpfa_word_type     tx_word,
    output hpfa_pkg::hpfa_vec_type      tx_word_valid,
    output hpfa_pkg::hpfa_fvec_type     tx_fast_word_valid
);
    import hpfa_pkg::*;

    hpfa_top_type          s_r;
    hpfa_top_type          s_nxt;
    hpfa_vec_type          slow_req;
    hpfa_vec_type          slow_grant;
    hpfa_vec_type          eff_req;
    hpfa_vec_type          grant_vec;
    hpfa_vec_type          fast_sel;
    hpfa_vec_type          tx_fast_sel;
    hpfa_vec_type          tx_eff;
    hpfa_fvec_type         fast_req;
    hpfa_fvec_type         fast_grant;
    hpfa_word_type         slow_word [`HPFA_NPORTS];
    hpfa_word_type         fast_word [`HPFA_NFAST];
    hpfa_word_type         eff_word  [`HPFA_NPORTS];
    logic [`HPFA_PORT_W:0] rx_win;
    logic [`HPFA_PORT_W:0] tx_win;
    logic                  load;

    // ----------------------------------------------------------------
    // engines and routing
    // ----------------------------------------------------------------
    for (genvar p = 0; p < `HPFA_NPORTS; p++) begin : g_port
        hpfa_packer u_slow (
            .clock   (clock),
            .nrst    (nrst),
            .bit_in  (rx_bit[p]),
            .bit_en  (rx_bit_en[p]),
            .chan_en (rx_chan_en[p] && !fast_sel[p]),
            .grant   (slow_grant[p]),
            .req     (slow_req[p]),
            .dword   (slow_word[p]),
            .overrun (rx_overrun[p])
        );
        if (p < `HPFA_NFAST) begin : g_fast
            hpfa_packer u_fast (
                .clock   (clock),
                .nrst    (nrst),
                .bit_in  (fast_rx_bit[p]),
                .bit_en  (fast_rx_bit_en[p]),
                .chan_en (rx_chan_en[p] && fast_sel[p]),
                .grant   (fast_grant[p]),
                .req     (fast_req[p]),
                .dword   (fast_word[p]),
                .overrun (fast_rx_overrun[p])
            );
            assign fast_sel[p]    = rx_port_control[p];
            assign tx_fast_sel[p] = tx_port_control[p];
            assign eff_req[p]  = fast_sel[p] ? fast_req[p] : slow_req[p];
            assign eff_word[p] = fast_sel[p] ? fast_word[p] : slow_word[p];
            assign tx_eff[p]   = tx_fast_sel[p] ? tx_fast_req[p] : tx_req[p];
            assign fast_grant[p] = grant_vec[p] && fast_sel[p];
        end else begin : g_slow_only
            // upper ports have no fast engine to route to
            assign fast_sel[p]    = 1'b0;
            assign tx_fast_sel[p] = 1'b0;
            assign eff_req[p]  = slow_req[p];
            assign eff_word[p] = slow_word[p];
            assign tx_eff[p]   = tx_req[p];
        end
        assign slow_grant[p] = grant_vec[p] && !fast_sel[p];
    end

    // ----------------------------------------------------------------
    // receive arbitration
    // ----------------------------------------------------------------
    // the output stage refills in the cycle it empties, so one dword
    // moves every clock: far above the aggregate line rate
    assign load   = !s_r.wr_valid || fifo_wr_ready;
    assign rx_win = hpfa_lowest(eff_req);
    assign tx_win = hpfa_lowest(tx_eff);
    assign grant_vec = (load && rx_win[`HPFA_PORT_W]) ?
        hpfa_vec_type'(16'h0001 << rx_win[`HPFA_PORT_W-1:0]) :
        '0;

    always_comb begin
        s_nxt = s_r;
        if (load) begin
            s_nxt.wr_valid = rx_win[`HPFA_PORT_W];
            if (rx_win[`HPFA_PORT_W]) begin
                // channel number is only a tag, it never ranks
                s_nxt.wr_port = rx_win[`HPFA_PORT_W-1:0];
                s_nxt.wr_data = eff_word[rx_win[`HPFA_PORT_W-1:0]];
                s_nxt.wr_chan = rx_chan[rx_win[`HPFA_PORT_W-1:0]];
            end
        end
        s_nxt.tx_valid      = '0;
        s_nxt.tx_fast_valid = '0;
        case (s_r.tx_st)
            TX_IDLE: begin
                if (tx_win[`HPFA_PORT_W]) begin
                    s_nxt.rd_port = tx_win[`HPFA_PORT_W-1:0];
                    s_nxt.tx_st   = TX_FETCH;
                end
            end
            TX_FETCH: begin
                if (fifo_rd_valid) begin
                    s_nxt.tx_word = fifo_rd_data;
                    if (tx_fast_sel[s_r.rd_port]) begin
                        s_nxt.tx_fast_valid =
                            hpfa_fvec_type'(2'h1 << s_r.rd_port[0]);
                    end else begin
                        s_nxt.tx_valid =
                            hpfa_vec_type'(16'h0001 << s_r.rd_port);
                    end
                    s_nxt.tx_st = TX_DONE;
                end
            end
            // one idle cycle lets the served engine drop its request
            TX_DONE: begin
                s_nxt.tx_st = TX_IDLE;
            end
            default: begin
                s_nxt.tx_st = TX_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign fifo_wr_valid      = s_r.wr_valid;
    assign fifo_wr_data       = s_r.wr_data;
    assign fifo_wr_port       = s_r.wr_port;
    assign fifo_wr_chan       = s_r.wr_chan;
    assign fifo_rd_req        = (s_r.tx_st == TX_FETCH);
    assign fifo_rd_port       = s_r.rd_port;
    assign tx_word            = s_r.tx_word;
    assign tx_word_valid      = s_r.tx_valid;
    assign tx_fast_word_valid = s_r.tx_fast_valid;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    property p_win_low;
        |grant_vec |-> $onehot(grant_vec) &&
            ((grant_vec - 16'h0001) & eff_req) == '0;
    endproperty
    a_win_low: assert property (p_win_low)
        else $error("grant not to the lowest requesting port");

    property p_port_tag;
        load && rx_win[`HPFA_PORT_W] |=> fifo_wr_valid &&
            fifo_wr_port == $past(rx_win[`HPFA_PORT_W-1:0]) &&
            fifo_wr_data == $past(eff_word[rx_win[`HPFA_PORT_W-1:0]]);
    endproperty
    a_port_tag: assert property (p_port_tag)
        else $error("written dword not from the winning port");

    property p_fast_route;
        (fast_grant & ~fast_sel[1:0]) == '0 &&
            (slow_grant & fast_sel) == '0;
    endproperty
    a_fast_route: assert property (p_fast_route)
        else $error("grant routed to the unselected engine");

    property p_upper_slow;
        fast_sel[`HPFA_NPORTS-1:`HPFA_NFAST] == '0;
    endproperty
    a_upper_slow: assert property (p_upper_slow)
        else $error("fast engine on a port above one");

    // no grant while the output stage is stuck; a grant may follow in
    // the very cycle the fifo takes the waiting dword
    sequence s_no_grant;
        grant_vec == '0;
    endsequence
    sequence s_word_kept;
        fifo_wr_valid && $stable(fifo_wr_data);
    endsequence
    property p_stall_hold;
        fifo_wr_valid && !fifo_wr_ready |-> s_no_grant ##1 s_word_kept;
    endproperty
    a_stall_hold: assert property (p_stall_hold)
        else $error("write dword lost or replaced under stall");

    property p_tx_pick;
        s_r.tx_st == TX_IDLE && tx_win[`HPFA_PORT_W] |=>
            fifo_rd_req &&
            fifo_rd_port == $past(tx_win[`HPFA_PORT_W-1:0]);
    endproperty
    a_tx_pick: assert property (p_tx_pick)
        else $error("transmit request not lowest port first");

    sequence s_rd_taken;
        fifo_rd_req && fifo_rd_valid;
    endsequence
    sequence s_word_out;
        ($countones({tx_word_valid, tx_fast_word_valid}) == 1) ##1
            (tx_word_valid == '0 && tx_fast_word_valid == '0);
    endsequence
    property p_one_word;
        s_rd_taken |=> s_word_out and
            (tx_word == $past(fifo_rd_data));
    endproperty
    a_one_word: assert property (p_one_word)
        else $error("transmit word not delivered once");
endmodule
`default_nettype wire

// ### dv/hpfa_fifo_model.sv
// behavioural fifo partner: write acceptance and transmit word fetches
`timescale 1ns/1ps
`default_nettype none
module hpfa_fifo_model (
    // clock and reset
    input  wire logic                    clock,
    input  wire logic                    nrst,
    // scenario controls
    input  wire logic                    stall,
    input  wire logic [3:0]              rd_delay,
    // write side
    output logic                         wr_ready,
    // read side
    input  wire logic                    rd_req,
    input  wire hpfa_pkg::hpfa_port_type rd_port,
    output logic                         rd_valid,
    output hpfa_pkg::hpfa_word_type      rd_data
);
    import hpfa_pkg::*;

    logic [3:0]    wait_r;
    hpfa_word_type last_r;

    // a stalled fifo refuses writes; the arbiter holds its waiting dword meanwhile
    assign wr_ready = ~stall;
    assign rd_valid = rd_req && (wait_r == rd_delay);
    // one whole word per fetch; between answers the bus shows junk
    assign rd_data  = rd_valid ? (32'h7E00_0000 | 32'(rd_port))
                               : ~last_r;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wait_r <= 4'h0;
            last_r <= 32'h0;
        end else begin
            wait_r <= (rd_req && !rd_valid) ? wait_r + 4'h1 : 4'h0;
            if (rd_valid) begin
                last_r <= rd_data;
            end
        end
    end
endmodule
`default_nettype wire

// ### dv/hpfa_arbiter_test.sv
// self-checking bench for the port-to-fifo arbiter
`timescale 1ns/1ps
`default_nettype none
`include "hpfa_regs.svh"
module hpfa_arbiter_test;
    import hpfa_pkg::*;

    logic           clock;
    logic           nrst;
    logic [1:0]     rx_port_control;
    logic [1:0]     tx_port_control;
    hpfa_vec_type   rx_bit;
    hpfa_vec_type   rx_bit_en;
    hpfa_fvec_type  fast_rx_bit;
    hpfa_fvec_type  fast_rx_bit_en;
    hpfa_vec_type   rx_chan_en;
    hpfa_chan_type  rx_chan [`HPFA_NPORTS];
    hpfa_vec_type   rx_overrun;
    hpfa_fvec_type  fast_rx_overrun;
    logic           fifo_wr_valid;
    logic           fifo_wr_ready;
    hpfa_word_type  fifo_wr_data;
    hpfa_port_type  fifo_wr_port;
    hpfa_chan_type  fifo_wr_chan;
    hpfa_vec_type   tx_req;
    hpfa_fvec_type  tx_fast_req;
    logic           fifo_rd_req;
    hpfa_port_type  fifo_rd_port;
    logic           fifo_rd_valid;
    hpfa_word_type  fifo_rd_data;
    hpfa_word_type  tx_word;
    hpfa_vec_type   tx_word_valid;
    hpfa_fvec_type  tx_fast_word_valid;
    logic           stall;
    logic [3:0]     rd_delay;
    logic [43:0]    wr_q [$];
    int             n_fail;
    int             n_compared;

    hpfa_arbiter hpfa_arbiter_i (.clock(clock), .nrst(nrst),
        .rx_port_control(rx_port_control), .tx_port_control(tx_port_control),
        .rx_bit(rx_bit), .rx_bit_en(rx_bit_en), .fast_rx_bit(fast_rx_bit),
        .fast_rx_bit_en(fast_rx_bit_en), .rx_chan_en(rx_chan_en),
        .rx_chan(rx_chan), .rx_overrun(rx_overrun),
        .fast_rx_overrun(fast_rx_overrun), .fifo_wr_valid(fifo_wr_valid),
        .fifo_wr_ready(fifo_wr_ready), .fifo_wr_data(fifo_wr_data),
        .fifo_wr_port(fifo_wr_port), .fifo_wr_chan(fifo_wr_chan),
        .tx_req(tx_req), .tx_fast_req(tx_fast_req),
        .fifo_rd_req(fifo_rd_req), .fifo_rd_port(fifo_rd_port),
        .fifo_rd_valid(fifo_rd_valid), .fifo_rd_data(fifo_rd_data),
        .tx_word(tx_word), .tx_word_valid(tx_word_valid),
        .tx_fast_word_valid(tx_fast_word_valid));

    hpfa_fifo_model hpfa_fifo_model_i (.clock(clock), .nrst(nrst),
        .stall(stall), .rd_delay(rd_delay), .wr_ready(fifo_wr_ready),
        .rd_req(fifo_rd_req), .rd_port(fifo_rd_port),
        .rd_valid(fifo_rd_valid), .rd_data(fifo_rd_data));

    // ------------------------------------------------------------
    // clock, monitor and shared tasks
    // ------------------------------------------------------------
    always #4 clock = ~clock;

    always @(posedge clock) begin
        if (fifo_wr_valid && fifo_wr_ready) begin
            wr_q.push_back({fifo_wr_chan, fifo_wr_port, fifo_wr_data});
        end
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // bits go out msb first, the same word on every selected engine
    task automatic shift_in(input hpfa_vec_type s, input hpfa_fvec_type f,
                            input hpfa_word_type w);
        for (int i = 31; i >= 0; i--) begin
            @(posedge clock);
            #1;
            rx_bit         = s & {16{w[i]}};
            rx_bit_en      = s;
            fast_rx_bit    = f & {2{w[i]}};
            fast_rx_bit_en = f;
        end
        @(posedge clock);
        #1;
        rx_bit_en      = '0;
        fast_rx_bit_en = '0;
    endtask

    // writes must leave in ascending physical port order
    task automatic drain_check(input hpfa_vec_type ports,
                               input hpfa_word_type w);
        logic [43:0] e;
        repeat (8) @(posedge clock);
        #1;
        cmp(32'(wr_q.size()), 32'($countones(ports)), "write count");
        for (int p = 0; p < 16; p++) begin
            if (ports[p] && wr_q.size() > 0) begin
                e = wr_q.pop_front();
                cmp(32'(e[35:32]), 32'(p), "write port");
                cmp(e[31:0], w, "write data");
                cmp(32'(e[43:36]), 32'(8'h7F - p), "write chan");
            end
        end
        wr_q.delete();
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_rx_prio;
        rx_chan_en = 16'hFFF7;
        shift_in(16'h802C, 2'b00, 32'hC3A5_0F81);
        drain_check(16'h8024, 32'hC3A5_0F81);
        rx_chan_en = 16'hFFFF;
        $display("test rx_prio done");
    endtask

    // slow engines of ports 0 and 1 are driven too and must stay silent
    task automatic t_rx_fast;
        rx_port_control = 2'b11;
        shift_in(16'h0013, 2'b11, 32'h8000_0001);
        drain_check(16'h0013, 32'h8000_0001);
        rx_port_control = 2'b00;
        $display("test rx_fast done");
    endtask

    task automatic t_rx_overrun;
        stall = 1'b1;
        repeat (3) shift_in(16'h0080, 2'b00, 32'h0F0F_1234);
        repeat (2) @(posedge clock);
        #1;
        cmp(32'(fifo_wr_valid), 32'd1, "held write valid");
        cmp(32'(rx_overrun), 32'h0080, "overrun flag");
        cmp(32'(fast_rx_overrun), 32'h0, "fast overrun flag");
        stall = 1'b0;
        repeat (8) @(posedge clock);
        #1;
        cmp(32'(wr_q.size()), 32'd2, "writes after stall");
        wr_q.delete();
        $display("test rx_overrun done");
    endtask

    task automatic t_tx;
        logic [4:0]  exp_id [4];
        logic [4:0]  id;
        logic [17:0] v;
        int          n;
        // port 0 also raises its slow request, which must be ignored
        exp_id          = '{5'h10, 5'h11, 5'h04, 5'h09};
        n               = 0;
        rd_delay        = 4'h2;
        tx_port_control = 2'b11;
        tx_fast_req     = 2'b11;
        tx_req          = 16'h0211;
        for (int c = 0; c < 80 && n < 4; c++) begin
            @(posedge clock);
            #1;
            v = {tx_fast_word_valid, tx_word_valid};
            if (v !== 18'h0) begin
                for (int k = 0; k < 18; k++) begin
                    if (v[k] === 1'b1) begin
                        id = 5'(k);
                    end
                end
                cmp(32'($countones(v)), 32'd1, "tx one-hot");
                cmp(32'(id), 32'(exp_id[n]), "tx order");
                cmp(tx_word, 32'h7E00_0000 | 32'(id[3:0]), "tx word");
                if (id[4]) begin
                    tx_fast_req[id[0]] = 1'b0;
                end else begin
                    tx_req[id[3:0]] = 1'b0;
                end
                rd_delay = 4'h0;
                n++;
            end
        end
        tx_req = '0;
        cmp(32'(n), 32'd4, "tx words served");
        $display("test tx done");
    endtask

    task automatic final_report;
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        {clock, nrst, stall, rd_delay} = '0;
        {rx_port_control, tx_port_control, rx_bit, rx_bit_en} = '0;
        {fast_rx_bit, fast_rx_bit_en, tx_req, tx_fast_req} = '0;
        rx_chan_en = 16'hFFFF;
        n_fail     = 0;
        n_compared = 0;
        for (int p = 0; p < 16; p++) begin
            rx_chan[p] = 8'(8'h7F - p);
        end
        repeat (2) @(posedge clock);
        #1;
        nrst = 1'b1;
        t_rx_prio();
        t_rx_fast();
        t_tx();
        t_rx_overrun();
        final_report();
    end

    // the whole run needs well under 600 cycles
    initial begin
        repeat (3000) @(posedge clock);
        n_fail++;
        $display("[FAIL] %0t watchdog expired", $time);
        final_report();
    end
endmodule
`default_nettype wire
